// [hw/serial_tx_control.sv]
// Transmit status and control register with its shift engine and pins
//
// The strobed register port was left to the implementer.
module serial_tx_control
   import serial_tx_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output reg_byte_t       reg_rdata,
   // Serial pins
   input  wire logic       serial_port_enable,
   input  wire logic       tx_clk_pin_in,
   output logic            tx_clk_pin_out,
   output logic            tx_clk_pin_oe,
   output logic            rx_data_pin_out,
   output logic            rx_data_pin_oe,
   // Interrupt
   output logic            irq
);
`include "serial_tx_defs.svh"
   tx_link_if link();

   logic       clk_src, nine, tx_en, sync_mode, high_speed, ninth;
   logic       next_clk_src, next_nine, next_tx_en, next_sync_mode;
   logic       next_high_speed, next_ninth;
   logic       empty_flag, next_empty;
   logic [1:0] stat, next_stat, mask, next_mask;
   logic       next_irq;
   reg_byte_t  next_rdata;
   logic [7:0] div_cnt, next_div_cnt, div_limit;
   logic       div_tick, clk_in_prev, slave_fall;
   logic       next_clk_out, next_clk_oe, next_data_out, next_data_oe;
   logic       wr_send;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
      hit = (a == b);
   endfunction

   tx_shifter u_shifter (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .link    (link)
   );

   // Control register and interrupt state
   always_comb begin
      next_clk_src    = clk_src;
      next_nine       = nine;
      next_tx_en      = tx_en;
      next_sync_mode  = sync_mode;
      next_high_speed = high_speed;
      next_ninth      = ninth;
      next_mask       = mask;
      next_stat       = stat;
      wr_send         = reg_wr && hit(reg_addr, `SEND_DATA_ADDR);
      if (reg_wr && hit(reg_addr, `TSC_ADDR)) begin
         // Bit three and the empty flag are not writable
         next_clk_src    = reg_wdata[`BIT_CLK_SRC];
         next_nine       = reg_wdata[`BIT_NINE];
         next_tx_en      = reg_wdata[`BIT_TX_EN];
         next_sync_mode  = reg_wdata[`BIT_SYNC];
         next_high_speed = reg_wdata[`BIT_HIGH_SPEED];
         next_ninth      = reg_wdata[`BIT_NINTH];
      end
      if (reg_wr && hit(reg_addr, `IRQ_MASK_ADDR)) next_mask = reg_wdata[1:0];
      if (reg_wr && hit(reg_addr, `IRQ_STAT_ADDR)) begin
         next_stat = stat & ~reg_wdata[1:0];
      end
      // Events are applied after the clear so a same-cycle set wins
      next_stat[`IRQ_DONE]    = next_stat[`IRQ_DONE]
                                | (!empty_flag && next_empty);
      next_stat[`IRQ_REFUSED] = next_stat[`IRQ_REFUSED]
                                | (wr_send && !link.load);
      next_irq = |(next_stat & next_mask);
   end

   // Send path: no holding buffer, so a word is only taken while idle
   always_comb begin
      link.load  = wr_send && tx_en && !link.busy;
      link.word  = {ninth, reg_wdata};
      link.nine  = nine;
      link.sync  = sync_mode;
      link.abort = !tx_en;
      next_empty = !link.load && !(link.busy && tx_en);
   end

   // Bit timing: divider in master/async, falling pin edge in slave
   always_comb begin
      div_limit  = sync_mode ? `DIV_SYNC :
                   (high_speed ? `DIV_HIGH : `DIV_LOW);
      div_tick   = link.busy && (div_cnt == div_limit - 8'h01);
      slave_fall = clk_in_prev && !tx_clk_pin_in;
      link.tick  = (sync_mode && !clk_src) ? slave_fall : div_tick;
      next_div_cnt = (!link.busy || div_tick) ? 8'h00 : div_cnt + 8'h01;
   end

   // Pin drive; nothing is driven until the port is enabled
   always_comb begin
      if (sync_mode) begin
         next_clk_out  = !(link.busy && clk_src) ||
                         (div_cnt >= (div_limit >> 1));
         next_clk_oe   = serial_port_enable && clk_src;
         next_data_out = link.line;
         next_data_oe  = serial_port_enable && tx_en;
      end else begin
         next_clk_out  = link.line;
         next_clk_oe   = serial_port_enable && tx_en;
         next_data_out = 1'b1;
         next_data_oe  = 1'b0;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_comb begin
      next_rdata = 8'h00;
      if (reg_rd) begin
         if (hit(reg_addr, `TSC_ADDR)) begin
            next_rdata = {clk_src, nine, tx_en, sync_mode,
                          1'b0, high_speed, empty_flag, ninth};
         end else if (hit(reg_addr, `IRQ_STAT_ADDR)) begin
            next_rdata = {6'h00, stat};
         end else if (hit(reg_addr, `IRQ_MASK_ADDR)) begin
            next_rdata = {6'h00, mask};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         clk_src         <= 1'(`TSC_RESET >> `BIT_CLK_SRC);
         nine            <= 1'b0;
         tx_en           <= 1'b0;
         sync_mode       <= 1'b0;
         high_speed      <= 1'b0;
         ninth           <= 1'b0;
         empty_flag      <= 1'b1;
         stat            <= 2'h0;
         mask            <= 2'h0;
         irq             <= 1'b0;
         reg_rdata       <= 8'h00;
         div_cnt         <= 8'h00;
         clk_in_prev     <= 1'b1;
         tx_clk_pin_out  <= 1'b1;
         tx_clk_pin_oe   <= 1'b0;
         rx_data_pin_out <= 1'b1;
         rx_data_pin_oe  <= 1'b0;
      end else begin
         clk_src         <= next_clk_src;
         nine            <= next_nine;
         tx_en           <= next_tx_en;
         sync_mode       <= next_sync_mode;
         high_speed      <= next_high_speed;
         ninth           <= next_ninth;
         empty_flag      <= next_empty;
         stat            <= next_stat;
         mask            <= next_mask;
         irq             <= next_irq;
         reg_rdata       <= next_rdata;
         div_cnt         <= next_div_cnt;
         clk_in_prev     <= tx_clk_pin_in;
         tx_clk_pin_out  <= next_clk_out;
         tx_clk_pin_oe   <= next_clk_oe;
         rx_data_pin_out <= next_data_out;
         rx_data_pin_oe  <= next_data_oe;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_load_needs_enable: assert property (
      link.load |-> tx_en)
      else $error("word loaded while transmitter disabled");
   // A same-cycle re-enable may load again, hence the next-value term
   a_disable_stops_tx: assert property (
      (!tx_en && !next_tx_en) |=> !link.busy ##1 empty_flag)
      else $error("disabled transmitter still busy");
   a_empty_on_load: assert property (
      (link.load || (link.busy && tx_en)) |=> !empty_flag)
      else $error("empty flag set while word in flight");
   a_empty_read_back: assert property (
      (reg_rd && reg_addr == `TSC_ADDR) |=>
      reg_rdata[`BIT_EMPTY] == $past(empty_flag))
      else $error("empty flag read back wrong");
   a_bit3_reads_zero: assert property (
      (reg_rd && reg_addr == `TSC_ADDR) |=> reg_rdata[`BIT_UNUSED] == 1'b0)
      else $error("unimplemented bit read as one");
   a_master_clk_drive: assert property (
      (sync_mode && clk_src && serial_port_enable) |=> tx_clk_pin_oe)
      else $error("sync master not driving clock");
   a_slave_clk_quiet: assert property (
      (sync_mode && !clk_src) |=> !tx_clk_pin_oe)
      else $error("sync slave driving clock");
   // Status flags and pin enables follow their causes one cycle later; irq matches stat and mask in the same cycle
   a_refuse_sets_flag: assert property (
      (wr_send && !link.load) |=> stat[`IRQ_REFUSED])
      else $error("dropped send write left no refused flag");
   a_done_sets_flag: assert property (
      (!empty_flag && next_empty) |=> stat[`IRQ_DONE])
      else $error("finished word left no done flag");
   a_irq_follows_status: assert property (
      irq == |(stat & mask))
      else $error("interrupt level does not match status and mask");
   a_async_line_drive: assert property (
      (!sync_mode && serial_port_enable && tx_en) |=> tx_clk_pin_oe)
      else $error("async transmitter not driving its line");
   a_sync_data_drive: assert property (
      (sync_mode && serial_port_enable && tx_en) |=> rx_data_pin_oe)
      else $error("sync transmitter not driving data pin");
   c_async_word: cover property (link.load && !sync_mode ##[1:900] empty_flag);
   c_sync_master: cover property (link.load && sync_mode && clk_src);
   c_refused_write: cover property (wr_send && link.busy);
endmodule

// [hw/serial_tx_defs.svh]
// Offsets, field positions, reset values and timing counts of the serial transmitter
`ifndef SERIAL_TX_DEFS_SVH
`define SERIAL_TX_DEFS_SVH
`define TSC_ADDR       8'h98
`define IRQ_STAT_ADDR  8'h9C
`define IRQ_MASK_ADDR  8'hA0
`define SEND_DATA_ADDR 8'hA4
`define BIT_CLK_SRC    7
`define BIT_NINE       6
`define BIT_TX_EN      5
`define BIT_SYNC       4
`define BIT_UNUSED     3
`define BIT_HIGH_SPEED 2
`define BIT_EMPTY      1
`define BIT_NINTH      0
`define TSC_RESET      8'h02
`define IRQ_DONE       0
`define IRQ_REFUSED    1
`define DIV_HIGH       8'h10
`define DIV_LOW        8'h40
`define DIV_SYNC       8'h04
`define LAST_BIT_8     4'h7
`define LAST_BIT_9     4'h8
`endif

// [hw/serial_tx_pkg.sv]
// Types shared by the serial transmitter modules
package serial_tx_pkg;
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_DATA  = 2'b11,
      ST_STOP  = 2'b10
   } shift_state_e;
   typedef logic [7:0] reg_byte_t;
endpackage

// [hw/tx_link_if.sv]
// Link between the transmit control and the shift engine
interface tx_link_if;
   logic       load;
   logic [8:0] word;
   logic       nine;
   logic       sync;
   logic       tick;
   logic       abort;
   logic       busy;
   logic       line;
   modport ctrl  (output load, word, nine, sync, tick, abort,
                  input  busy, line);
   modport shift (input  load, word, nine, sync, tick, abort,
                  output busy, line);
endinterface

// [hw/tx_shifter.sv]
// Transmit shift engine: start bit, 8 or 9 data bits, stop bit in async; only the 8 or 9 data bits in sync
module tx_shifter
   import serial_tx_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Control link
   tx_link_if.shift link
);
`include "serial_tx_defs.svh"
   shift_state_e state;
   shift_state_e next_state;
   logic [8:0]   shreg;
   logic [8:0]   next_shreg;
   logic [3:0]   cnt;
   logic [3:0]   next_cnt;
   logic [3:0]   last_bit;

   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_cnt   = cnt;
      last_bit   = link.nine ? `LAST_BIT_9 : `LAST_BIT_8;
      case (state)
         ST_IDLE: begin
            if (link.load) begin
               next_shreg = link.word;
               next_cnt   = 4'h0;
               next_state = link.sync ? ST_DATA : ST_START;
            end
         end
         ST_START: begin
            if (link.tick) next_state = ST_DATA;
         end
         ST_DATA: begin
            if (link.tick) begin
               next_shreg = {1'b1, shreg[8:1]};
               next_cnt   = cnt + 4'h1;
               if (cnt == last_bit) begin
                  next_state = link.sync ? ST_IDLE : ST_STOP;
               end
            end
         end
         ST_STOP: begin
            if (link.tick) next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // Disabling the transmitter drops any word in flight
      if (link.abort) next_state = ST_IDLE;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state <= ST_IDLE;
         shreg <= 9'h1FF;
         cnt   <= 4'h0;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         cnt   <= next_cnt;
      end
   end

   assign link.busy = (state != ST_IDLE);
   assign link.line = (state == ST_START) ? 1'b0 :
                      (state == ST_DATA)  ? shreg[0] : 1'b1;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   a_eight_bit_end: assert property (
      (state == ST_DATA && link.tick && cnt == 4'h7 && !link.nine
       && !link.abort) |=> state != ST_DATA)
      else $error("8-bit word did not end after eighth bit");
   a_nine_bit_more: assert property (
      (state == ST_DATA && link.tick && cnt == 4'h7 && link.nine
       && !link.abort) |=> state == ST_DATA && cnt == 4'h8)
      else $error("9-bit word ended after eighth bit");
   c_nine_bit_word: cover property (
      state == ST_DATA && link.tick && cnt == 4'h8);
endmodule

// [tb/serial_rx_model.sv]
// Far-side receiver model: async frames on TX/CK, sync data on RX/DT
module serial_rx_model (
   // Clock and bench control
   input  wire logic       clk_sys,
   input  wire logic       arm,
   input  wire logic       sync,
   input  var  int         half_bit,
   input  var  int         nbits,
   // Wire levels
   input  wire logic       tx_line,
   input  wire logic       dt_line,
   // Captured word
   output logic [8:0]      word,
   output logic            done
);
   timeunit 1ns;
   timeprecision 1ns;
   // Async samples mid-bit so a slip of a few cycles still reads right
   always begin
      @(posedge arm);
      done = 1'b0;
      word = '0;
      if (sync) begin
         for (int i = 0; i < nbits; i++) begin
            @(posedge tx_line);
            word[i] = dt_line;
         end
      end else begin
         @(negedge tx_line);
         repeat (half_bit) @(posedge clk_sys);
         for (int i = 0; i < nbits; i++) begin
            repeat (2 * half_bit) @(posedge clk_sys);
            word[i] = tx_line;
         end
      end
      done = 1'b1;
   end
endmodule

// [tb/testbench.sv]
// Self-checking bench of the serial transmit control block
`include "serial_tx_defs.svh"
module testbench;
   import serial_tx_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk_sys, rst_b, reg_wr, reg_rd, port_en, ext_ck, arm, sync;
   logic [7:0] reg_addr, reg_wdata;
   reg_byte_t  reg_rdata, rv;
   logic       ck_out, ck_oe, dt_out, dt_oe, irq, done;
   logic [8:0] word;
   int         half_bit, nbits, err_count, check_count;
   // Idle pull-up on RX/DT; undriven TX/CK takes the bench level ext_ck
   wire logic  tx_wire = ck_oe ? ck_out : ext_ck;
   wire logic  dt_wire = dt_oe ? dt_out : 1'b1;
   serial_tx_control dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .serial_port_enable(port_en), .tx_clk_pin_in(tx_wire),
      .tx_clk_pin_out(ck_out), .tx_clk_pin_oe(ck_oe),
      .rx_data_pin_out(dt_out), .rx_data_pin_oe(dt_oe), .irq(irq));
   serial_rx_model rx_u (.clk_sys(clk_sys), .arm(arm), .sync(sync),
      .half_bit(half_bit), .nbits(nbits), .tx_line(tx_wire),
      .dt_line(dt_wire), .word(word), .done(done));
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [8:0] e, g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input string n, input logic [7:0] a, e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      chk(n, {1'b0, e}, {1'b0, rv});
   endtask
   task automatic wait_for(input bit on_irq);
      for (int i = 0; i < 3000 && (on_irq ? irq : done) !== 1'b1; i++)
         @(posedge clk_sys);
      if ((on_irq ? irq : done) !== 1'b1) begin
         err_count++;
         $display("BAD wait expired");
         tally_and_finish;
      end
   endtask
   // Arms the receiver, configures, then loads one word
   task automatic send(input logic [7:0] cfg, d, input int h, n, logic s);
      @(posedge clk_sys);
      sync <= s;
      half_bit <= h;
      nbits <= n;
      arm <= 1'b1;
      wr(`TSC_ADDR, cfg);
      wr(`SEND_DATA_ADDR, d);
      arm <= 1'b0;
   endtask
   task automatic t_reset_fields;
      rchk("ctrl reset", `TSC_ADDR, 8'h02);
      rchk("unmapped", 8'h55, 8'h00);
      wr(`TSC_ADDR, 8'hFF);
      rchk("ctrl all ones", `TSC_ADDR, 8'hF7);
      chk("ck oe gated", 9'h000, {8'h00, ck_oe});
      wr(`TSC_ADDR, 8'h00);
   endtask
   task automatic word_done(input string n, input logic [8:0] e);
      wait_for(1'b0);
      chk(n, e, word);
      wait_for(1'b1);
      rchk("done status", `IRQ_STAT_ADDR, 8'h01);
      wr(`IRQ_STAT_ADDR, 8'h01);
      #1 chk("irq cleared", 9'h000, {8'h00, irq});
   endtask
   task automatic t_async;
      port_en <= 1'b1;
      wr(`IRQ_MASK_ADDR, 8'h01);
      send(8'h24, 8'hA5, 8, 8, 1'b0);
      rchk("empty low", `TSC_ADDR, 8'h24);
      word_done("async 8 bit", 9'h0A5);
      rchk("empty again", `TSC_ADDR, 8'h26);
      send(8'h61, 8'h3C, 32, 9, 1'b0);
      word_done("async 9 bit", 9'h13C);
   endtask
   task automatic t_sync;
      send(8'hB0, 8'h5A, 2, 8, 1'b1);
      #1 chk("master oes", 9'h003, {7'h00, ck_oe, dt_oe});
      word_done("sync master", 9'h05A);
      wr(`TSC_ADDR, 8'h30);
      @(posedge clk_sys);
      #1 chk("slave oes", 9'h001, {7'h00, ck_oe, dt_oe});
   endtask
   // External master: rise lets the far side sample, fall shifts on
   task automatic t_slave;
      @(posedge clk_sys);
      ext_ck <= 1'b0;
      repeat (4) @(posedge clk_sys);
      sync <= 1'b1;
      nbits <= 8;
      arm <= 1'b1;
      wr(`SEND_DATA_ADDR, 8'hC3);
      arm <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         repeat (4) @(posedge clk_sys);
         ext_ck <= 1'b1;
         repeat (4) @(posedge clk_sys);
         ext_ck <= 1'b0;
      end
      word_done("sync slave", 9'h0C3);
      @(posedge clk_sys);
      ext_ck <= 1'b1;
   endtask
   task automatic t_refuse_abort;
      wr(`IRQ_MASK_ADDR, 8'h02);
      wr(`TSC_ADDR, 8'h04);
      wr(`SEND_DATA_ADDR, 8'h77);
      wait_for(1'b1);
      rchk("off refused", `IRQ_STAT_ADDR, 8'h02);
      wr(`IRQ_STAT_ADDR, 8'h02);
      wr(`TSC_ADDR, 8'h24);
      wr(`SEND_DATA_ADDR, 8'hFF);
      wr(`SEND_DATA_ADDR, 8'h11);
      rchk("busy refused", `IRQ_STAT_ADDR, 8'h02);
      rchk("running", `TSC_ADDR, 8'h24);
      wr(`TSC_ADDR, 8'h04);
      rchk("aborted", `TSC_ADDR, 8'h06);
   endtask
   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      port_en = 1'b0;
      ext_ck = 1'b1;
      arm = 1'b0;
      sync = 1'b0;
      half_bit = 8;
      nbits = 8;
      err_count = 0;
      check_count = 0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_reset_fields();
      t_async();
      t_sync();
      t_slave();
      t_refuse_abort();
      tally_and_finish();
   end
endmodule
